// *** hw/tmz_pkg.sv ***
package tmz_pkg;

    // Register byte addresses on the APB bus
    localparam logic [7:0] ADDR_CONFIG   = 8'h00;
    localparam logic [7:0] ADDR_COUNT    = 8'h04;
    localparam logic [7:0] ADDR_INTCTL   = 8'h08;
    localparam logic [7:0] ADDR_PORTDIR  = 8'h0C;
    localparam logic [7:0] ADDR_CONTROL  = 8'h10;
    localparam logic [7:0] ADDR_STATUS   = 8'h14;
    localparam logic [7:0] ADDR_MASK     = 8'h18;

    // Reset values
    localparam logic [7:0] CONFIG_RST    = 8'hFF;
    localparam logic [7:0] PORTDIR_RST   = 8'hFF;
    localparam logic [7:0] INTCTL_RST    = 8'h00;
    localparam logic [7:0] COUNT_RST     = 8'h00;

    // Configuration field positions
    localparam int CFG_SRC_BIT   = 5;
    localparam int CFG_EDGE_BIT  = 4;
    localparam int CFG_ASSIGN_BIT = 3;
    localparam int CFG_RATE_LSB  = 0;
    localparam int RATE_W        = 3;

    // Interrupt control field positions
    localparam int INT_IE_BIT    = 5;
    localparam int INT_FLAG_BIT  = 2;

    // Control register bits
    localparam int CTL_CLEAR_WATCHDOG_INSTRUCTION_BIT = 0;
    localparam int CTL_SLEEP_BIT  = 1;

    // Sticky event status bits
    localparam int EVT_OVF   = 0;
    localparam int EVT_PSOUT = 1;
    localparam int EVT_W     = 2;

    // Write inhibit length in instruction cycles
    localparam int INHIBIT_CYC = 2;

    localparam logic [7:0] CNT_MAX = 8'hFF;

    typedef struct packed {
        logic       src_sel;
        logic       edge_sel;
        logic       assign_sel;
        logic [2:0] rate_sel;
    } tmz_cfg_t;

endpackage

// *** hw/tmz_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module tmz_timer
    import tmz_pkg::*;
#(
    parameter int PS_W = 8
)(
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_ext_count_input,
    output logic             o_wdt_tick,
    output logic             o_irq
);

    initial
    begin
        if (PS_W != 8)
            $error("tmz_timer: PS_W must be 8");
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0]         cfg_q;
    logic [7:0]         count_q;
    logic [7:0]         intctl_q;
    logic [7:0]         portdir_q;
    logic               sleep_q;
    logic [EVT_W-1:0]   status_q;
    logic [EVT_W-1:0]   mask_q;
    logic [PS_W-1:0]    ps_q;
    logic [1:0]         phase_q;
    logic [1:0]         inhibit_q;
    logic [2:0]         ext_sync_q;
    logic               ext_seen_q;
    logic               ps_out_q;
    logic               ps_tap_q;

    tmz_cfg_t cfg;
    assign cfg = '{src_sel:    cfg_q[CFG_SRC_BIT],
                   edge_sel:   cfg_q[CFG_EDGE_BIT],
                   assign_sel: cfg_q[CFG_ASSIGN_BIT],
                   rate_sel:   cfg_q[CFG_RATE_LSB +: RATE_W]};

    logic wr_en;
    logic rd_en;
    logic wr_count;
    logic wr_intctl;
    logic clr_wdt;
    assign wr_en     = i_psel && i_penable && i_pwrite;
    assign rd_en     = i_psel && i_penable && !i_pwrite;
    assign wr_count  = wr_en && (i_paddr == ADDR_COUNT);
    assign wr_intctl = wr_en && (i_paddr == ADDR_INTCTL);
    assign clr_wdt   = wr_en && (i_paddr == ADDR_CONTROL) && i_pwdata[CTL_CLEAR_WATCHDOG_INSTRUCTION_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Instruction clock: four phases per instruction cycle

    logic instr_tick;
    assign instr_tick = (phase_q == 2'h3);

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            phase_q <= 2'h0;
        else
            phase_q <= phase_q + 2'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // External input synchroniser and edge detection

    logic ext_edge;
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            ext_sync_q <= 3'h0;
        else
            ext_sync_q <= {ext_sync_q[1:0], i_ext_count_input};
    end

    // Edge counted once the second and third stages agree on the new level
    assign ext_edge = (ext_sync_q[1] == ext_sync_q[2]) && (ext_sync_q[2] != ext_seen_q);

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            ext_seen_q <= 1'b0;
        else if (ext_edge)
            ext_seen_q <= ext_sync_q[2];
    end

    logic ext_event;
    // Edge bit set counts falling edges, clear counts rising edges
    assign ext_event = ext_edge && (ext_sync_q[2] == !cfg.edge_sel);

    logic src_event;
    assign src_event = cfg.src_sel ? ext_event : instr_tick;

    ////////////////////////////////////////////////////////////////////////
    // Shared prescaler

    logic ps_run;
    assign ps_run = cfg.assign_sel ? instr_tick : src_event;

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            ps_q <= '0;
        else if ((wr_count && !cfg.assign_sel) || (clr_wdt && cfg.assign_sel))
            ps_q <= '0;
        // Only the timer freezes in sleep; the watchdog side keeps its time base
        else if (ps_run && !(sleep_q && !cfg.assign_sel))
            ps_q <= ps_q + 1'b1;
    end

    // Tap bit: timer uses bit rate, a square wave of 2..256 source events
    logic ps_tap;
    always_comb
    begin
        ps_tap = ps_q[cfg.rate_sel];
    end

    // Watchdog side: carry out of the low rate bits, one step in 1..128
    logic [PS_W-1:0] wdt_mask;
    logic            wdt_carry;
    assign wdt_mask  = (PS_W'(1) << cfg.rate_sel) - PS_W'(1);
    assign wdt_carry = &(ps_q | ~wdt_mask);

    // Prescaler output sampled on second and fourth phases
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ps_tap_q <= 1'b0;
            ps_out_q <= 1'b0;
        end
        else if (phase_q[0])
        begin
            ps_tap_q <= ps_tap;
            ps_out_q <= ps_tap && !ps_tap_q && !cfg.assign_sel;
        end
        else
            ps_out_q <= 1'b0;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_wdt_tick <= 1'b0;
        else
            // Watchdog time base: carry when attached, else every instruction cycle
            o_wdt_tick <= cfg.assign_sel ? (wdt_carry && ps_run) : instr_tick;
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter

    logic inc;
    always_comb
    begin
        inc = cfg.assign_sel ? src_event : ps_out_q;
        if (sleep_q || inhibit_q != 2'h0)
            inc = 1'b0;
    end

    // Counts down on instruction ticks, so the hold spans two instruction cycles
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            inhibit_q <= 2'h0;
        else if (wr_count)
            inhibit_q <= 2'(INHIBIT_CYC);
        else if (instr_tick && inhibit_q != 2'h0)
            inhibit_q <= inhibit_q - 2'h1;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            count_q <= COUNT_RST;
        else if (wr_count)
            count_q <= i_pwdata[7:0];
        else if (inc)
            count_q <= count_q + 8'h01;
    end

    logic ovf;
    assign ovf = inc && (count_q == CNT_MAX);

    ////////////////////////////////////////////////////////////////////////
    // Interrupt control: flag set wins over a software clear

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            intctl_q <= INTCTL_RST;
        else
        begin
            if (wr_intctl)
                intctl_q <= i_pwdata[7:0];
            if (ovf)
                intctl_q[INT_FLAG_BIT] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration, direction, sleep, mask

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            cfg_q <= CONFIG_RST;
        else if (wr_en && i_paddr == ADDR_CONFIG)
            cfg_q <= i_pwdata[7:0];
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            portdir_q <= PORTDIR_RST;
        else if (wr_en && i_paddr == ADDR_PORTDIR)
            portdir_q <= i_pwdata[7:0];
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            sleep_q <= 1'b0;
        else if (wr_en && i_paddr == ADDR_CONTROL)
            sleep_q <= i_pwdata[CTL_SLEEP_BIT];
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            mask_q <= '0;
        else if (wr_en && i_paddr == ADDR_MASK)
            mask_q <= i_pwdata[EVT_W-1:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky events, cleared by reading status

    logic [EVT_W-1:0] evt;
    assign evt = {ps_out_q, ovf};

    logic rd_status;
    assign rd_status = rd_en && (i_paddr == ADDR_STATUS);

    // A read clears only the bits it returned, so an event during setup is kept
    genvar g;
    generate
        for (g = 0; g < EVT_W; g++)
        begin : g_evt
            always_ff @(posedge i_clk or negedge i_rstn)
            begin
                if (!i_rstn)
                    status_q[g] <= 1'b0;
                else if (evt[g])
                    status_q[g] <= 1'b1;
                else if (rd_status && o_prdata[g])
                    status_q[g] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_irq <= 1'b0;
        else
            o_irq <= (intctl_q[INT_FLAG_BIT] && intctl_q[INT_IE_BIT])
                     || |(status_q & mask_q);
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, error on unmapped address
    // Read data is captured in setup and stands through the access cycle

    logic [31:0] rdata;
    logic        hit;
    always_comb
    begin
        rdata = 32'h0;
        hit   = 1'b1;
        unique case (i_paddr)
            ADDR_CONFIG:  rdata[7:0] = cfg_q;
            ADDR_COUNT:   rdata[7:0] = count_q;
            ADDR_INTCTL:  rdata[7:0] = intctl_q;
            ADDR_PORTDIR: rdata[7:0] = portdir_q;
            ADDR_CONTROL: rdata[CTL_SLEEP_BIT] = sleep_q;
            ADDR_STATUS:  rdata[EVT_W-1:0] = status_q;
            ADDR_MASK:    rdata[EVT_W-1:0] = mask_q;
            default:      hit = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0;
        end
        else
        begin
            o_pready  <= i_psel && !i_penable;
            o_pslverr <= i_psel && !i_penable && !hit;
            o_prdata  <= (i_psel && !i_penable && !i_pwrite) ? rdata : 32'h0;
        end
    end

endmodule
`default_nettype wire

// *** verif/tmz_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tmz_pin_model (
    input  wire logic i_clk,
    output logic      o_pin
);
    // Pin rests low between bursts of pulses
    initial o_pin = 1'b0;

    task automatic send(input int cnt);
        repeat (cnt)
        begin
            @(posedge i_clk);
            o_pin <= 1'b1;
            repeat (6) @(posedge i_clk);
            o_pin <= 1'b0;
            repeat (5) @(posedge i_clk);
        end
    endtask
endmodule
`default_nettype wire

// *** verif/tmz_timer_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module tmz_timer_chk
    import tmz_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_rstn,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        o_wdt_tick,
    input wire logic        o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    wire logic setup  = i_psel && !i_penable;
    wire logic mapped = i_paddr[1:0] == 2'h0 && i_paddr <= ADDR_MASK;
    wire logic ie_wr  = i_psel && i_penable && o_pready && i_pwrite && i_paddr == ADDR_INTCTL;

    a_ready_setup: assert property (setup |=> o_pready)
        else $error("ready missing");
    a_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("ready too long");
    a_err_bad: assert property (setup && !mapped |=> o_pslverr)
        else $error("no error on bad address");
    a_err_good: assert property (setup && mapped |=> !o_pslverr)
        else $error("error on good address");
    a_err_zero: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
        else $error("bad read not zero");
    a_read_upper: assert property (o_pready && !i_pwrite |-> o_prdata[31:8] == 24'h0)
        else $error("upper bits set");
    a_tick_gap: assert property ($rose(o_wdt_tick) |=> !o_wdt_tick [*3])
        else $error("tick too close");
    a_irq_flag: assert property (ie_wr && i_pwdata[INT_IE_BIT] && i_pwdata[INT_FLAG_BIT]
        |-> ##[1:2] o_irq)
        else $error("irq missing");

    c_irq: cover property (o_irq);
    c_err: cover property (o_pslverr);
    c_tick: cover property ($rose(o_wdt_tick));
endmodule

bind tmz_timer tmz_timer_chk i_chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_wdt_tick(o_wdt_tick), .o_irq(o_irq));
`default_nettype wire

// *** verif/tmz_timer_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module tmz_timer_test
    import tmz_pkg::*;
;
    logic        clk, rstn, psel, penable, pwrite, rdy, err, re, pin, tick, irq;
    logic [7:0]  paddr, rq, a0;
    logic [31:0] pwdata, prdata;
    int          bad_count, cmp_count, n;

    tmz_timer i_dut (.i_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(rdy), .o_pslverr(err), .i_ext_count_input(pin), .o_wdt_tick(tick),
        .o_irq(irq));
    tmz_pin_model i_pin (.i_clk(clk), .o_pin(pin));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (rdy !== 1'b1)
            @(posedge clk);
        rq = prdata[7:0];
        re = err;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 8'h00);
    endtask

    task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %0h seen %0h", s, exp, seen);
        end
    endtask

    task automatic stop_test;
        if (bad_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic t_regs;
        rd(ADDR_CONFIG);
        chk("config", rq, CONFIG_RST);
        rd(ADDR_PORTDIR);
        chk("portdir", rq, PORTDIR_RST);
        rd(8'h1C);
        chk("unmapped", rq, 8'h00);
        chk("slverr", re, 1'b1);
    endtask

    task automatic t_prescale;
        wr(ADDR_CONTROL, 8'h01);
        for (int r = 0; r < 8; r++)
        begin
            wr(ADDR_CONFIG, 8'(r));
            wr(ADDR_COUNT, 8'h00);
            repeat (12) @(posedge clk);
            rd(ADDR_COUNT);
            a0 = rq;
            repeat ((1 << (r + 5)) - 3) @(posedge clk);
            rd(ADDR_COUNT);
            chk("prescale", rq - a0, 8'h04);
        end
        wr(ADDR_CONFIG, 8'h20);
        wr(ADDR_COUNT, 8'h00);
        repeat (10) @(posedge clk);
        i_pin.send(4);
        repeat (8) @(posedge clk);
        rd(ADDR_COUNT);
        chk("ext_div2", rq, 8'h02);
    endtask

    task automatic t_div1;
        wr(ADDR_CONTROL, 8'h01);
        wr(ADDR_COUNT, 8'h00);
        wr(ADDR_CONFIG, 8'h0F);
        wr(ADDR_CONTROL, 8'h01);
        wr(ADDR_CONFIG, 8'h0F);
        wr(ADDR_COUNT, 8'h40);
        rd(ADDR_COUNT);
        chk("inhibit", rq, 8'h40);
        repeat (8) @(posedge clk);
        rd(ADDR_COUNT);
        a0 = rq;
        repeat (37) @(posedge clk);
        rd(ADDR_COUNT);
        chk("div1", rq - a0, 8'h0A);
    endtask

    task automatic t_wdt;
        wr(ADDR_CONTROL, 8'h01);
        @(posedge clk);
        n = 0;
        while (tick !== 1'b1 && n < 700)
        begin
            @(posedge clk);
            n++;
        end
        chk("wdt_gap", 8'(n >= 500 && n <= 530), 8'h01);
    endtask

    task automatic t_overflow;
        wr(ADDR_INTCTL, 8'h00);
        wr(ADDR_COUNT, 8'hFD);
        repeat (40) @(posedge clk);
        rd(ADDR_INTCTL);
        chk("flag", rq, 8'h04);
        chk("irq_off", irq, 1'b0);
        wr(ADDR_MASK, 8'h01);
        repeat (2) @(posedge clk);
        chk("irq_mask", irq, 1'b1);
        rd(ADDR_STATUS);
        chk("status", rq[0], 1'b1);
        repeat (2) @(posedge clk);
        chk("irq_clr", irq, 1'b0);
        wr(ADDR_INTCTL, 8'h24);
        repeat (2) @(posedge clk);
        chk("irq_on", irq, 1'b1);
        wr(ADDR_INTCTL, 8'h20);
        repeat (2) @(posedge clk);
        chk("irq_sw", irq, 1'b0);
        wr(ADDR_MASK, 8'h00);
    endtask

    task automatic t_extern;
        wr(ADDR_CONFIG, 8'h28);
        wr(ADDR_COUNT, 8'h00);
        repeat (10) @(posedge clk);
        i_pin.send(5);
        repeat (8) @(posedge clk);
        rd(ADDR_COUNT);
        chk("rising", rq, 8'h05);
        wr(ADDR_CONFIG, 8'h38);
        wr(ADDR_COUNT, 8'h00);
        repeat (10) @(posedge clk);
        i_pin.send(3);
        repeat (8) @(posedge clk);
        rd(ADDR_COUNT);
        chk("falling", rq, 8'h03);
    endtask

    task automatic t_sleep;
        wr(ADDR_CONFIG, 8'h0F);
        wr(ADDR_CONTROL, 8'h02);
        rd(ADDR_COUNT);
        a0 = rq;
        repeat (37) @(posedge clk);
        rd(ADDR_COUNT);
        chk("sleep", rq, a0);
        wr(ADDR_CONTROL, 8'h00);
    endtask

    task automatic t_reset;
        wr(ADDR_CONTROL, 8'h01);
        wr(ADDR_CONFIG, 8'h00);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        chk("rst_irq", irq, 1'b0);
        chk("rst_tick", tick, 1'b0);
        rstn <= 1'b1;
        @(posedge clk);
        rd(ADDR_CONFIG);
        chk("rst_config", rq, CONFIG_RST);
        rd(ADDR_COUNT);
        chk("rst_count", rq, COUNT_RST);
    endtask

    initial
    begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_regs();
        t_prescale();
        t_div1();
        t_wdt();
        t_overflow();
        t_extern();
        t_sleep();
        t_reset();
        stop_test();
    end

    initial
    begin
        repeat (40000) @(posedge clk);
        bad_count++;
        stop_test();
    end
endmodule
`default_nettype wire
